// file: logic/ctl_port_pkg.sv
// Shared constants and types for the tuner control port
package ctl_port_pkg;
  // Three-wire chip address field and two-wire device address
  localparam logic [3:0] CHIP_ID3   = 4'h6;
  localparam logic [6:0] DEV_ADDR2  = 7'h10;
  // Byte pointer start points: register 02h high, register 0Ah high
  localparam logic [4:0] WR_START   = 5'h04;
  localparam logic [4:0] RD_START   = 5'h14;
  // Bit counts
  localparam logic [4:0] BYTE_BITS  = 5'h08;
  localparam logic [4:0] CTRL3_LAST = 5'h08;
  localparam logic [4:0] WORD_BITS  = 5'h10;
  localparam logic [4:0] WORD_LAST  = 5'h0f;
  // Control word field positions, order A7 A6 A5 RW A4 A3..A0
  localparam int unsigned CW_RW_POS = 5;
  localparam logic [15:0] REG_DEFAULT = 16'h0000;
  localparam int unsigned NUM_REGS    = 16;

  typedef logic [15:0][15:0] regfile_t;

  // Pins that enter from outside the clock domain
  typedef struct packed {
    logic rst_n;
    logic sclk;
    logic sdio;
    logic cs_n;
    logic gio1;
    logic gio3;
  } pins_t;

  localparam pins_t PINS_IDLE = 6'h1e;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_ADDR  = 4'h1,
    ST_AACK  = 4'h3,
    ST_WDATA = 4'h2,
    ST_WACK  = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK  = 4'h5,
    ST_SKIP  = 4'h4,
    ST_CTRL3 = 4'hc,
    ST_WR3   = 4'hd,
    ST_RD3   = 4'hf
  } state_t;
endpackage : ctl_port_pkg

// file: logic/tuner_dual_mode_control_port.sv
// Dual-mode (three-wire / two-wire) register access port of the tuner
`timescale 1ns/10ps
`default_nettype none

module tuner_dual_mode_control_port (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  reset_pin_n,
  input  wire logic                  sclk,
  input  wire logic                  sdio_in,
  output logic                       sdio_out,
  output logic                       sdio_oe,
  input  wire logic                  chip_select_n,
  input  wire logic                  general_io_one,
  input  wire logic                  general_io_three,
  output ctl_port_pkg::regfile_t     reg_image,
  output logic                       two_wire_mode,
  output logic                       port_enabled
);

  // ==========================================================
  // Pin synchronisers and edge detection
  ctl_port_pkg::pins_t sy1_reg;
  ctl_port_pkg::pins_t sy2_reg;
  ctl_port_pkg::pins_t prv_reg;
  ctl_port_pkg::pins_t pins_raw;

  assign pins_raw = '{rst_n: reset_pin_n, sclk: sclk, sdio: sdio_in,
                      cs_n: chip_select_n, gio1: general_io_one,
                      gio3: general_io_three};

  always_ff @(posedge clk) begin
    if (srst) begin
      sy1_reg <= ctl_port_pkg::PINS_IDLE;
      sy2_reg <= ctl_port_pkg::PINS_IDLE;
      prv_reg <= ctl_port_pkg::PINS_IDLE;
    end else begin
      sy1_reg <= pins_raw;
      sy2_reg <= sy1_reg;
      prv_reg <= sy2_reg;
    end
  end

  logic port_rst;
  logic rise;
  logic fall;
  logic start_ev;
  logic stop_ev;
  logic two_wire_reg;
  logic port_on_reg;

  assign port_rst = srst | ~sy2_reg.rst_n;
  assign rise     = port_on_reg & sy2_reg.sclk & ~prv_reg.sclk;
  assign fall     = port_on_reg & ~sy2_reg.sclk & prv_reg.sclk;
  assign start_ev = port_on_reg & two_wire_reg & sy2_reg.sclk & prv_reg.sclk
                    & prv_reg.sdio & ~sy2_reg.sdio;
  assign stop_ev  = port_on_reg & two_wire_reg & sy2_reg.sclk & prv_reg.sclk
                    & ~prv_reg.sdio & sy2_reg.sdio;

  // ==========================================================
  // Bus mode straps, caught as the reset pin goes high
  always_ff @(posedge clk) begin
    if (srst) begin
      two_wire_reg <= 1'b0;
      port_on_reg  <= 1'b0;
    end else if (!sy2_reg.rst_n) begin
      port_on_reg  <= 1'b0;
    end else if (!prv_reg.rst_n) begin
      port_on_reg  <= 1'b1;
      two_wire_reg <= sy2_reg.gio3 ? sy2_reg.gio1 : sy2_reg.cs_n;
    end
  end

  // ==========================================================
  // Transfer engine; runs from the system clock only, so no
  // reference clock is involved in register access
  // no reference clock
  ctl_port_pkg::state_t st_reg, st_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic [15:0] sh_reg, sh_next;
  logic [4:0]  ptr_reg, ptr_next;
  logic        rw_reg, rw_next;
  logic        ack_reg, ack_next;
  logic        oe_reg, oe_next;
  logic        do_reg, do_next;
  logic [3:0]  addr_reg, addr_next;
  ctl_port_pkg::regfile_t regs_reg, regs_next;
  logic [7:0]  byte_at;
  logic [8:0]  cw9;

  assign byte_at = ptr_reg[0] ? regs_reg[ptr_reg[4:1]][7:0]
                              : regs_reg[ptr_reg[4:1]][15:8];
  assign cw9     = {sh_reg[7:0], sy2_reg.sdio};

  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    sh_next   = sh_reg;
    ptr_next  = ptr_reg;
    rw_next   = rw_reg;
    ack_next  = ack_reg;
    oe_next   = oe_reg;
    do_next   = do_reg;
    addr_next = addr_reg;
    regs_next = regs_reg;
    if (two_wire_reg) begin
      // open drain, data level stays low
      do_next = 1'b0;
      if (start_ev) begin
        st_next  = ctl_port_pkg::ST_ADDR;
        cnt_next = 5'h00;
        oe_next  = 1'b0;
      end else if (stop_ev) begin
        st_next  = ctl_port_pkg::ST_IDLE;
        oe_next  = 1'b0;
        ptr_next = ctl_port_pkg::WR_START;
      end else begin
        unique case (st_reg)
          ctl_port_pkg::ST_IDLE, ctl_port_pkg::ST_SKIP: begin
          end
          ctl_port_pkg::ST_ADDR: begin
            if (rise && cnt_reg < ctl_port_pkg::BYTE_BITS) begin
              sh_next  = {sh_reg[14:0], sy2_reg.sdio};
              cnt_next = cnt_reg + 5'h01;
            end else if (fall && cnt_reg == ctl_port_pkg::BYTE_BITS) begin
              if (sh_reg[7:1] == ctl_port_pkg::DEV_ADDR2) begin
                st_next  = ctl_port_pkg::ST_AACK;
                oe_next  = 1'b1;
                rw_next  = sh_reg[0];
                ptr_next = sh_reg[0] ? ctl_port_pkg::RD_START
                                     : ctl_port_pkg::WR_START;
              end else begin
                st_next = ctl_port_pkg::ST_SKIP;
              end
            end
          end
          ctl_port_pkg::ST_AACK: begin
            if (fall) begin
              if (rw_reg) begin
                // first read bit on falling edge
                st_next  = ctl_port_pkg::ST_RDATA;
                sh_next  = {8'h00, byte_at};
                oe_next  = ~byte_at[7];
                cnt_next = 5'h01;
              end else begin
                st_next  = ctl_port_pkg::ST_WDATA;
                oe_next  = 1'b0;
                cnt_next = 5'h00;
              end
            end
          end
          ctl_port_pkg::ST_WDATA: begin
            if (rise && cnt_reg < ctl_port_pkg::BYTE_BITS) begin
              sh_next  = {sh_reg[14:0], sy2_reg.sdio};
              cnt_next = cnt_reg + 5'h01;
            end else if (fall && cnt_reg == ctl_port_pkg::BYTE_BITS) begin
              if (ptr_reg[0]) begin
                regs_next[ptr_reg[4:1]][7:0] = sh_reg[7:0];
              end else begin
                regs_next[ptr_reg[4:1]][15:8] = sh_reg[7:0];
              end
              ptr_next = ptr_reg + 5'h01;
              st_next  = ctl_port_pkg::ST_WACK;
              oe_next  = 1'b1;
            end
          end
          ctl_port_pkg::ST_WACK: begin
            if (fall) begin
              st_next  = ctl_port_pkg::ST_WDATA;
              oe_next  = 1'b0;
              cnt_next = 5'h00;
            end
          end
          ctl_port_pkg::ST_RDATA: begin
            if (fall) begin
              if (cnt_reg < ctl_port_pkg::BYTE_BITS) begin
                sh_next  = {sh_reg[14:0], 1'b0};
                oe_next  = ~sh_reg[6];
                cnt_next = cnt_reg + 5'h01;
              end else begin
                st_next  = ctl_port_pkg::ST_RACK;
                oe_next  = 1'b0;
                ptr_next = ptr_reg + 5'h01;
              end
            end
          end
          ctl_port_pkg::ST_RACK: begin
            if (rise) begin
              ack_next = ~sy2_reg.sdio;
            end else if (fall) begin
              if (ack_reg) begin
                st_next  = ctl_port_pkg::ST_RDATA;
                sh_next  = {8'h00, byte_at};
                oe_next  = ~byte_at[7];
                cnt_next = 5'h01;
              end else begin
                st_next = ctl_port_pkg::ST_SKIP;
              end
            end
          end
          default: begin
            st_next = ctl_port_pkg::ST_IDLE;
            oe_next = 1'b0;
          end
        endcase
      end
    end else if (rise) begin
      if (sy2_reg.cs_n) begin
        // end on rise with chip select high
        st_next = ctl_port_pkg::ST_IDLE;
        oe_next = 1'b0;
      end else begin
        unique case (st_reg)
          ctl_port_pkg::ST_IDLE: begin
            st_next  = ctl_port_pkg::ST_CTRL3;
            sh_next  = {15'h0000, sy2_reg.sdio};
            cnt_next = 5'h01;
          end
          ctl_port_pkg::ST_CTRL3: begin
            sh_next  = {sh_reg[14:0], sy2_reg.sdio};
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == ctl_port_pkg::CTRL3_LAST) begin
              rw_next   = cw9[ctl_port_pkg::CW_RW_POS];
              addr_next = cw9[3:0];
              cnt_next  = 5'h00;
              if ({cw9[8:6], cw9[4]} != ctl_port_pkg::CHIP_ID3) begin
                st_next = ctl_port_pkg::ST_SKIP;
              end else if (cw9[ctl_port_pkg::CW_RW_POS]) begin
                st_next = ctl_port_pkg::ST_RD3;
              end else begin
                st_next = ctl_port_pkg::ST_WR3;
              end
            end
          end
          ctl_port_pkg::ST_WR3: begin
            sh_next  = {sh_reg[14:0], sy2_reg.sdio};
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == ctl_port_pkg::WORD_LAST) begin
              regs_next[addr_reg] = {sh_reg[14:0], sy2_reg.sdio};
              st_next = ctl_port_pkg::ST_SKIP;
            end
          end
          ctl_port_pkg::ST_RD3: begin
            if (cnt_reg < ctl_port_pkg::WORD_BITS) begin
              do_next  = regs_reg[addr_reg][4'hf - cnt_reg[3:0]];
              oe_next  = 1'b1;
              cnt_next = cnt_reg + 5'h01;
            end
          end
          ctl_port_pkg::ST_SKIP: begin
          end
          default: begin
            st_next = ctl_port_pkg::ST_IDLE;
            oe_next = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (port_rst) begin
      st_reg   <= ctl_port_pkg::ST_IDLE;
      cnt_reg  <= 5'h00;
      sh_reg   <= 16'h0000;
      ptr_reg  <= ctl_port_pkg::WR_START;
      rw_reg   <= 1'b0;
      ack_reg  <= 1'b0;
      oe_reg   <= 1'b0;
      do_reg   <= 1'b0;
      addr_reg <= 4'h0;
      regs_reg <= {ctl_port_pkg::NUM_REGS{ctl_port_pkg::REG_DEFAULT}};
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      sh_reg   <= sh_next;
      ptr_reg  <= ptr_next;
      rw_reg   <= rw_next;
      ack_reg  <= ack_next;
      oe_reg   <= oe_next;
      do_reg   <= do_next;
      addr_reg <= addr_next;
      regs_reg <= regs_next;
    end
  end

  assign sdio_out      = do_reg;
  assign sdio_oe       = oe_reg;
  assign reg_image     = regs_reg;
  assign two_wire_mode = two_wire_reg;
  assign port_enabled  = port_on_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_stop;
    stop_ev;
  endsequence
  sequence s_idle_quiet;
    st_reg == ctl_port_pkg::ST_IDLE && !sdio_oe;
  endsequence

  property p_rst_idle;
    !sy2_reg.rst_n |=> s_idle_quiet;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("port not idle in reset");

  property p_od_low;
    two_wire_mode |-> !sdio_out;
  endproperty
  a_od_low: assert property (p_od_low) else $error("two-wire drove high");

  property p_stop_ptr;
    s_stop |=> s_idle_quiet ##0 ptr_reg == ctl_port_pkg::WR_START;
  endproperty
  a_stop_ptr: assert property (p_stop_ptr) else $error("STOP did not reset");

  property p_addr_ack;
    st_reg == ctl_port_pkg::ST_ADDR && fall && !start_ev && !stop_ev
      && cnt_reg == ctl_port_pkg::BYTE_BITS && sh_reg[7:1] == ctl_port_pkg::DEV_ADDR2
      |=> sdio_oe && st_reg == ctl_port_pkg::ST_AACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address ack missing");

  // Acknowledge holds the line low until the next falling clock
  property p_ack_hold;
    st_reg == ctl_port_pkg::ST_AACK && !fall && !start_ev && !stop_ev |=> sdio_oe;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("address ack released early");

  property p_skip_quiet;
    !two_wire_mode && st_reg == ctl_port_pkg::ST_SKIP && rw_reg |-> !sdio_oe;
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("foreign transfer driven");

  property p_cs_end;
    !two_wire_mode && rise && sy2_reg.cs_n |=> s_idle_quiet;
  endproperty
  a_cs_end: assert property (p_cs_end) else $error("transfer not ended");

  property p_ptr_step;
    st_reg == ctl_port_pkg::ST_WDATA && fall && !start_ev && !stop_ev
      && cnt_reg == ctl_port_pkg::BYTE_BITS |=> ptr_reg == $past(ptr_reg) + 5'h01;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step");

  property p_strap;
    sy2_reg.rst_n && !prv_reg.rst_n
      |=> two_wire_mode == $past(sy2_reg.gio3 ? sy2_reg.gio1 : sy2_reg.cs_n);
  endproperty
  a_strap: assert property (p_strap) else $error("bus mode strap wrong");

  property p_rd3_bit;
    !two_wire_mode && st_reg == ctl_port_pkg::ST_RD3 && rise && !sy2_reg.cs_n
      && cnt_reg < ctl_port_pkg::WORD_BITS
      |=> sdio_oe && sdio_out == $past(regs_reg[addr_reg][4'hf - cnt_reg[3:0]]);
  endproperty
  a_rd3_bit: assert property (p_rd3_bit) else $error("read bit wrong");

endmodule : tuner_dual_mode_control_port

`default_nettype wire

// file: testbench/host_ctl_model.sv
// Host controller model that drives the serial control bus
`timescale 1ns/10ps
`default_nettype none

module host_ctl_model (
  input  wire logic clk,
  input  wire logic line,
  output logic      sclk,
  output logic      cs_n,
  output logic      h_oe,
  output logic      h_val
);
  // ==========================================
  // Pin state and bus cycles
  // no crystal, no tuning modelled
  initial begin
    sclk  = 1'b0;
    cs_n  = 1'b1;
    h_oe  = 1'b0;
    h_val = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic park(input logic s, input logic c, input logic d);
    sclk  <= s;
    cs_n  <= c;
    h_oe  <= d;
    h_val <= 1'b0;
  endtask : park

  // data set in low phase, sampled at end of high phase
  task automatic bit_cycle(input logic v, input logic en, input int hi, output logic smp);
    h_oe  <= en;
    h_val <= v;
    tick(7 - hi);
    sclk <= 1'b1;
    tick(hi);
    smp = line;
    sclk <= 1'b0;
    tick(1);
  endtask : bit_cycle

  // chip select low for 25 rises, one more rise after release
  task automatic xfer3(input logic [8:0] cw, input logic [15:0] wd, output logic [15:0] rd);
    logic s;
    cs_n <= 1'b0;
    for (int i = 24; i >= 0; i--) begin
      if (i > 15) begin
        bit_cycle(cw[i - 16], 1'b1, 6, s);
      end else begin
        bit_cycle(wd[i], !cw[5], 6, s);
        rd[i] = s;
      end
    end
    cs_n <= 1'b1;
    bit_cycle(1'b0, 1'b0, 6, s);
  endtask : xfer3

  // host only pulls low, relies on the pull-up for ones
  task automatic start2();
    h_oe <= 1'b0;
    sclk <= 1'b1;
    tick(4);
    h_oe <= 1'b1;
    tick(4);
    sclk <= 1'b0;
    tick(1);
  endtask : start2

  // data rises while the clock is high
  task automatic stop2();
    h_oe <= 1'b1;
    tick(4);
    sclk <= 1'b1;
    tick(4);
    h_oe <= 1'b0;
    tick(4);
  endtask : stop2

  // ack_in low asks for a further byte
  task automatic byte2(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                       output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b0, !tx[i], 3, s);
      rx[i] = s;
    end
    bit_cycle(1'b0, !ack_in, 3, ack);
  endtask : byte2
endmodule : host_ctl_model
`default_nettype wire

// file: testbench/tb_tuner_dual_mode_control_port.sv
// Self-checking testbench for the tuner dual-mode control port
`timescale 1ns/10ps
`default_nettype none

module tb_tuner_dual_mode_control_port;
  logic                   clk;
  logic                   srst;
  logic                   reset_pin_n;
  logic                   general_io_one;
  logic                   general_io_three;
  logic                   sclk;
  logic                   chip_select_n;
  logic                   h_oe;
  logic                   h_val;
  logic                   sdio_out;
  logic                   sdio_oe;
  logic                   sdio_wire;
  logic                   flt_reg;
  logic                   oe_seen;
  ctl_port_pkg::regfile_t reg_image;
  logic                   two_wire_mode;
  logic                   port_enabled;
  int                     miscompares;
  int                     cmp_count;

  // ==========================================
  // Wire resolution, pull-up only in two-wire; a floating three-wire pin wanders
  assign sdio_wire = ((sdio_oe && !sdio_out) || (h_oe && !h_val)) ? 1'b0 :
                     (sdio_oe || h_oe || two_wire_mode) ? 1'b1 : flt_reg;

  tuner_dual_mode_control_port DUT (
    .clk(clk), .srst(srst), .reset_pin_n(reset_pin_n), .sclk(sclk), .sdio_in(sdio_wire),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .chip_select_n(chip_select_n),
    .general_io_one(general_io_one), .general_io_three(general_io_three),
    .reg_image(reg_image), .two_wire_mode(two_wire_mode), .port_enabled(port_enabled)
  );

  host_ctl_model host (
    .clk(clk), .line(sdio_wire), .sclk(sclk), .cs_n(chip_select_n), .h_oe(h_oe),
    .h_val(h_val)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    flt_reg <= ~flt_reg;
    if (sdio_oe === 1'b1)
      oe_seen <= 1'b1;
    if (two_wire_mode === 1'b1 && sdio_oe === 1'b1)
      chk_bit(sdio_out, 1'b0);
  end

  // ==========================================
  // Compare and report
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic end_sim();
    $display("comparisons=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // ==========================================
  // Expected data
  function automatic logic [8:0] cw3(input logic [3:0] chip, input logic rw, input logic [3:0] a);
    return {chip[3:1], rw, chip[0], a};
  endfunction : cw3

  function automatic logic [7:0] wbyte(input int k);
    return 8'(k * 37 + 5);
  endfunction : wbyte

  // Register contents after both two-wire writes
  function automatic logic [15:0] exp_reg(input int n);
    if (n == 1)
      return 16'h0000;
    if (n == 2)
      return 16'h5a96;
    return {wbyte(2 * ((n + 14) % 16)), wbyte(2 * ((n + 14) % 16) + 1)};
  endfunction : exp_reg

  // ==========================================
  // Scenarios
  task automatic pin_reset(input logic c, input logic g1, input logic g3, input logic tw);
    reset_pin_n      <= 1'b0;
    general_io_one   <= g1;
    general_io_three <= g3;
    host.park(1'b1, c, 1'b1);
    repeat (6) @(posedge clk);
    chk_bit(port_enabled, 1'b0);
    reset_pin_n <= 1'b1;
    repeat (8) @(posedge clk);
    host.park(tw, 1'b1, 1'b0);
    repeat (8) @(posedge clk);
    chk_bit(port_enabled, 1'b1);
    chk_bit(two_wire_mode, tw);
    for (int r = 0; r < 16; r++)
      chk_word(reg_image[r], 16'h0000);
  endtask : pin_reset

  task automatic s_three_wire();
    logic [15:0] rd;
    host.xfer3(cw3(ctl_port_pkg::CHIP_ID3, 1'b0, 4'h2), 16'h1234, rd);
    chk_word(reg_image[2], 16'h1234);
    host.xfer3(cw3(ctl_port_pkg::CHIP_ID3, 1'b0, 4'hf), 16'hc3a5, rd);
    chk_word(reg_image[15], 16'hc3a5);
    host.xfer3(cw3(ctl_port_pkg::CHIP_ID3, 1'b1, 4'h2), 16'h0000, rd);
    chk_word(rd, 16'h1234);
    oe_seen <= 1'b0;
    host.xfer3(cw3(4'h7, 1'b0, 4'h3), 16'hffff, rd);
    host.xfer3(cw3(4'he, 1'b1, 4'h2), 16'h0000, rd);
    chk_bit(oe_seen, 1'b0);
    chk_word(reg_image[3], 16'h0000);
  endtask : s_three_wire

  task automatic s_two_wire_write();
    logic [7:0] rx;
    logic       ack;
    host.start2();
    host.byte2({ctl_port_pkg::DEV_ADDR2, 1'b0}, 1'b1, rx, ack);
    chk_bit(ack, 1'b0);
    for (int k = 0; k < 30; k++) begin
      host.byte2(wbyte(k), 1'b1, rx, ack);
      chk_bit(ack, 1'b0);
    end
    host.stop2();
    host.start2();
    host.byte2({ctl_port_pkg::DEV_ADDR2, 1'b0}, 1'b1, rx, ack);
    host.byte2(8'h5a, 1'b1, rx, ack);
    host.byte2(8'h96, 1'b1, rx, ack);
    host.stop2();
    for (int n = 0; n < 16; n++)
      chk_word(reg_image[n], exp_reg(n));
  endtask : s_two_wire_write

  task automatic s_two_wire_read();
    logic [7:0]  rx;
    logic        ack;
    logic [15:0] e;
    host.start2();
    host.byte2({ctl_port_pkg::DEV_ADDR2, 1'b1}, 1'b1, rx, ack);
    chk_bit(ack, 1'b0);
    for (int k = 0; k < 14; k++) begin
      host.byte2(8'hff, k == 13, rx, ack);
      e = exp_reg((10 + k / 2) % 16);
      chk_word({8'h00, rx}, {8'h00, k[0] ? e[7:0] : e[15:8]});
    end
    host.stop2();
    host.start2();
    host.byte2({7'h11, 1'b1}, 1'b1, rx, ack);
    chk_bit(ack, 1'b1);
    host.stop2();
    host.start2();
    host.byte2({ctl_port_pkg::DEV_ADDR2, 1'b1}, 1'b1, rx, ack);
    host.byte2(8'hff, 1'b1, rx, ack);
    e = exp_reg(10);
    chk_word({8'h00, rx}, {8'h00, e[15:8]});
    host.stop2();
  endtask : s_two_wire_read

  // ==========================================
  // Main sequence
  initial begin
    logic [3:0] tbl [3];
    tbl              = '{4'b1001, 4'b1010, 4'b0111};
    srst             = 1'b1;
    reset_pin_n      = 1'b0;
    general_io_one   = 1'b0;
    general_io_three = 1'b0;
    flt_reg          = 1'b0;
    oe_seen          = 1'b0;
    miscompares      = 0;
    cmp_count        = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    chk_bit(sdio_oe, 1'b0);
    pin_reset(1'b0, 1'b1, 1'b0, 1'b0);
    s_three_wire();
    for (int m = 0; m < 3; m++)
      pin_reset(tbl[m][3], tbl[m][2], tbl[m][1], tbl[m][0]);
    s_two_wire_write();
    s_two_wire_read();
    end_sim();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule : tb_tuner_dual_mode_control_port
`default_nettype wire
